//--- common/dsf_pkg.sv
// Purpose: shared constants for the dual-output fault supervisor
// Assumes: 250 MHz core clock, 8-bit serial messages
// Notes: serial field positions, reset values and timing counts live here
//
// Functional notes
// RULE1: loss of logic supply resets all configuration and fault registers.
// RULE2: without logic supply, direct pins still drive outputs; protection keeps default settings.
// RULE3: fault indicator goes low on overtemp, open load, overcurrent, over or undervoltage.
// RULE4: indicator releases when the fault clears, except overcurrent and latched undervoltage.
// RULE5: fault flags are shifted out on the first valid transfer, then cleared.
// RULE6: overtemperature is only evaluated while the output is commanded on.
// RULE7: overtemperature turns the output off until it cools, repeating without limit.
// RULE8: overtemperature flag is sticky until a valid read or power reset.
// RULE9: overvoltage holds outputs off; its flag sits in status bit one until read.
// RULE10: overvoltage disable bit suppresses both overvoltage shutdown and reporting.
// RULE11: undervoltage turns outputs off, pulls the indicator low, sets the undervoltage flag.
// RULE12: undervoltage recovery with output off releases the indicator; flag stays until read.
// RULE13: undervoltage recovery with output on keeps it off until commanded off then on.
// RULE14: undervoltage disable suppresses indicator and flag; outputs hold above critical supply.
// RULE15: open load is checked only while off, once the gate has been pulled low.
// RULE16: open load flag clears on a status read once the condition is gone.
// RULE17: open load disable bit turns open load detection off.
// RULE18: eight low-tier and two high-tier current thresholds, one of each monitored.
// RULE19: low-tier overcurrent held past the blanking time latches the output off.
// RULE20: high-tier overcurrent latches the output off immediately.
// RULE21: after overcurrent latch-off the output needs an off then on command.
// RULE22: full duplex serial link, clock, data in, data out, select, MSB first.
// RULE23: messages are eight bits; lengths not a multiple of eight are ignored.
// RULE24: status loads at select falling; received data latches at select rising.
// RULE25: each output keeps its own fault and latch-off state.
// RULE26: commanded on is the direct pin OR the serial on bit.

package dsf_pkg;
   localparam int CLK_MHZ = 250;
   localparam int NUM_OUT = 2;
   localparam int WORD_BITS = 8;

   // ************************************************************
   // serial message layout
   // ************************************************************
   localparam int ADDR_LSB = 4;
   localparam int SEL_BIT = 7;
   localparam logic [2:0] ADDR_STATUS = 3'h0;
   localparam logic [2:0] ADDR_OUTCTL = 3'h1;
   localparam logic [2:0] ADDR_CURLIM = 3'h2;
   localparam logic [2:0] ADDR_LOADTIME = 3'h3;
   localparam logic [2:0] ADDR_SUPPLY = 3'h6;
   localparam int OUTCTL_ON0_BIT = 0;
   localparam int OUTCTL_ON1_BIT = 2;
   localparam int CURLIM_HIGH_BIT = 3;
   localparam int LOADTIME_OLDIS_BIT = 3;
   localparam int SUPPLY_UVDIS_BIT = 1;
   localparam int SUPPLY_OVDIS_BIT = 0;

   // ************************************************************
   // status byte layout
   // ************************************************************
   localparam int ST_UV_BIT = 0;
   localparam int ST_OV_BIT = 1;
   localparam int ST_OT_LSB = 2;
   localparam int ST_OL_LSB = 4;
   localparam int ST_OC_LSB = 6;

   // ************************************************************
   // reset values
   // ************************************************************
   localparam logic [2:0] LOW_SEL_RST = 3'h0;
   localparam logic HIGH_SEL_RST = 1'b0;
   localparam logic [1:0] BLANK_SEL_RST = 2'h0;
   localparam logic OLDIS_RST = 1'b0;
   localparam logic UVDIS_RST = 1'b0;
   localparam logic OVDIS_RST = 1'b0;
   localparam logic ON_SPI_RST = 1'b0;
   localparam int SYNC_W = 19;
   // select pin idles high, so its synchroniser resets high
   localparam logic [SYNC_W-1:0] SYNC_RST = 19'h00001;

   // ************************************************************
   // low-tier blanking times, least times rounded up
   // ************************************************************
   localparam int BLANK_CNT_W = 12;
   localparam int BLANK_NS_0 = 250;
   localparam int BLANK_NS_1 = 500;
   localparam int BLANK_NS_2 = 1000;
   localparam int BLANK_NS_3 = 2000;
   localparam logic [BLANK_CNT_W-1:0] BLANK_CYC [4] = '{
      BLANK_CNT_W'((BLANK_NS_0 * CLK_MHZ + 999) / 1000),
      BLANK_CNT_W'((BLANK_NS_1 * CLK_MHZ + 999) / 1000),
      BLANK_CNT_W'((BLANK_NS_2 * CLK_MHZ + 999) / 1000),
      BLANK_CNT_W'((BLANK_NS_3 * CLK_MHZ + 999) / 1000)};

   typedef enum logic [1:0] {
      LINK_IDLE = 2'b01,
      LINK_SHIFT = 2'b10
   } dsf_link_e;
endpackage

//--- verilog/dsf_output_guard.sv
// Purpose: protection and fault state of one power output
// Assumes: all inputs already synchronised to clk
// Notes: analog comparators supply the hysteresis on overtemperature

`timescale 1ns/100ps
`default_nettype none

module dsf_output_guard import dsf_pkg::*; #(
   parameter int CNT_W = BLANK_CNT_W
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // command and supply state
   input wire logic cmdOn,
   input wire logic ovActive,
   input wire logic uvActive,
   input wire logic supplyCritical,
   // sensors
   input wire logic overTemp,
   input wire logic openLoad,
   input wire logic gateOff,
   input wire logic ocLow,
   input wire logic ocHigh,
   // configuration
   input wire logic [CNT_W-1:0] blankCycles,
   input wire logic olDisable,
   // flag clears
   input wire logic clrOt,
   input wire logic clrOl,
   input wire logic clrOc,
   // state out
   output logic outOn,
   output logic otFlag,
   output logic olFlag,
   output logic ocFlag,
   output logic faultActive
);
   logic outOn_reg, outOn_next;
   logic otOff_reg, otOff_next;
   logic ocLatch_reg, ocLatch_next;
   logic uvLatch_reg, uvLatch_next;
   logic otFlag_reg, otFlag_next;
   logic olFlag_reg, olFlag_next;
   logic ocFlag_reg, ocFlag_next;
   logic [CNT_W-1:0] ocCnt_reg, ocCnt_next;
   logic olDetect;
   logic lowTrip;

   // ************************************************************
   // next-state logic
   // ************************************************************
   always_comb begin
      otOff_next = cmdOn & overTemp; // [RULE6] [RULE7]
      ocCnt_next = '0;
      if (ocLow && ocCnt_reg != {CNT_W{1'b1}}) begin
         ocCnt_next = CNT_W'(ocCnt_reg + 1'b1);
      end else if (ocLow) begin
         ocCnt_next = ocCnt_reg;
      end
      lowTrip = ocLow && (ocCnt_reg >= blankCycles); // [RULE19]
      // dropping the command is the only way out of a latch-off
      ocLatch_next = cmdOn & (ocLatch_reg | ocHigh | lowTrip); // [RULE20] [RULE21] [RULE25]
      uvLatch_next = cmdOn & (uvLatch_reg | uvActive); // [RULE13]
      outOn_next = cmdOn & ~otOff_next & ~ocLatch_next & ~uvLatch_next & ~uvActive
         & ~ovActive & ~supplyCritical; // [RULE9] [RULE11] [RULE14]
      olDetect = ~outOn_reg & ~cmdOn & gateOff & openLoad & ~olDisable; // [RULE15] [RULE17]
      // a set in the clearing cycle survives
      otFlag_next = otOff_next | (otFlag_reg & ~clrOt); // [RULE8]
      olFlag_next = olDetect | (olFlag_reg & ~clrOl); // [RULE16]
      ocFlag_next = ocLatch_next | (ocFlag_reg & ~clrOc);
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         outOn_reg <= 1'b0;
         otOff_reg <= 1'b0;
         ocLatch_reg <= 1'b0;
         uvLatch_reg <= 1'b0;
         otFlag_reg <= 1'b0;
         olFlag_reg <= 1'b0;
         ocFlag_reg <= 1'b0;
         ocCnt_reg <= '0;
      end else begin
         outOn_reg <= outOn_next;
         otOff_reg <= otOff_next;
         ocLatch_reg <= ocLatch_next;
         uvLatch_reg <= uvLatch_next;
         otFlag_reg <= otFlag_next;
         olFlag_reg <= olFlag_next;
         ocFlag_reg <= ocFlag_next;
         ocCnt_reg <= ocCnt_next;
      end
   end

   assign outOn = outOn_reg;
   assign otFlag = otFlag_reg;
   assign olFlag = olFlag_reg;
   assign ocFlag = ocFlag_reg;
   assign faultActive = otOff_reg | olDetect | ocLatch_reg | uvLatch_reg; // [RULE3] [RULE4]
endmodule

`default_nettype wire

//--- verilog/dsf_supervisor.sv
// Purpose: fault supervisor and serial slave for a two-output high-side switch
// Assumes: every pin input is asynchronous; serial clock idles low
// Notes: the serial link is oversampled by clk, so its clock must stay well below clk/4

`timescale 1ns/100ps
`default_nettype none

module dsf_supervisor import dsf_pkg::*; (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // supply monitors
   input wire logic logicSupplyOk,
   input wire logic supplyOverVoltage,
   input wire logic supplyUnderVoltage,
   input wire logic supplyBelowCritical,
   // direct control pins
   input wire logic [NUM_OUT-1:0] directOutputInputs,
   // per-output sensors
   input wire logic [NUM_OUT-1:0] overTemp,
   input wire logic [NUM_OUT-1:0] openLoad,
   input wire logic [NUM_OUT-1:0] gateOff,
   input wire logic [NUM_OUT-1:0] overCurrentLow,
   input wire logic [NUM_OUT-1:0] overCurrentHigh,
   // serial link
   input wire logic sclk,
   input wire logic sdi,
   input wire logic csN,
   output logic sdo,
   output logic sdoOe,
   // power stage
   output logic [NUM_OUT-1:0] powerOutputOn,
   output logic [NUM_OUT-1:0][2:0] lowTierCurrentLimit,
   output logic [NUM_OUT-1:0] highTierCurrentLimit,
   output logic faultIndicatorN
);
   logic [SYNC_W-1:0] syncA_reg, syncB_reg;
   logic supOk, supOv, supUv, supCrit, sclkS, sdiS, csS;
   logic [NUM_OUT-1:0] dIn, ot, ol, gOff, ocL, ocH;

   dsf_link_e linkState_reg, linkState_next;
   logic [WORD_BITS-1:0] shift_reg, shift_next;
   logic [WORD_BITS-1:0] reported_reg, reported_next;
   logic [2:0] bitCnt_reg, bitCnt_next;
   logic byteSeen_reg, byteSeen_next;
   logic sdo_reg, sdo_next;
   logic sdoOe_reg, sdoOe_next;
   logic readClr_reg, readClr_next;
   logic sclkPrev_reg, csPrev_reg;
   logic wrEn;

   logic [NUM_OUT-1:0] onSpi_reg, onSpi_next;
   logic [NUM_OUT-1:0][2:0] lowSel_reg, lowSel_next;
   logic [NUM_OUT-1:0] highSel_reg, highSel_next;
   logic [NUM_OUT-1:0][1:0] blankSel_reg, blankSel_next;
   logic [NUM_OUT-1:0] olDis_reg, olDis_next;
   logic uvDis_reg, uvDis_next;
   logic ovDis_reg, ovDis_next;

   logic ovFlag_reg, ovFlag_next;
   logic uvFlag_reg, uvFlag_next;
   logic faultN_reg, faultN_next;
   logic ovActive, uvActive;
   logic [NUM_OUT-1:0] cmdOn, outOn, otFlag, olFlag, ocFlag, guardFault;
   logic [NUM_OUT-1:0] clrOt, clrOl, clrOc;
   logic [WORD_BITS-1:0] statusByte, clrMask;
   logic [2:0] wAddr;
   int wSel;

   // ************************************************************
   // input synchronisers
   // ************************************************************
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         syncA_reg <= SYNC_RST;
         syncB_reg <= SYNC_RST;
      end else begin
         syncA_reg <= {logicSupplyOk, supplyOverVoltage, supplyUnderVoltage, supplyBelowCritical,
            directOutputInputs, overTemp, openLoad, gateOff, overCurrentLow, overCurrentHigh, sclk, sdi, csN};
         syncB_reg <= syncA_reg;
      end
   end

   assign {supOk, supOv, supUv, supCrit, dIn, ot, ol, gOff, ocL, ocH, sclkS, sdiS, csS} = syncB_reg;

   // ************************************************************
   // serial shifter
   // ************************************************************
   always_comb begin
      linkState_next = linkState_reg;
      shift_next = shift_reg;
      reported_next = reported_reg;
      bitCnt_next = bitCnt_reg;
      byteSeen_next = byteSeen_reg;
      sdo_next = sdo_reg;
      sdoOe_next = sdoOe_reg;
      readClr_next = 1'b0;
      wrEn = 1'b0;
      case (linkState_reg)
         LINK_IDLE: begin
            sdoOe_next = 1'b0;
            if (supOk && csPrev_reg && !csS) begin
               // capture status at select fall [RULE24] [RULE5]
               linkState_next = LINK_SHIFT;
               shift_next = statusByte;
               reported_next = statusByte;
               sdo_next = statusByte[WORD_BITS-1];
               sdoOe_next = 1'b1;
               bitCnt_next = 3'h0;
               byteSeen_next = 1'b0;
            end
         end
         LINK_SHIFT: begin
            if (!supOk) begin
               linkState_next = LINK_IDLE;
               sdoOe_next = 1'b0;
            end else if (csS) begin
               linkState_next = LINK_IDLE;
               sdoOe_next = 1'b0;
               // only whole bytes are accepted [RULE23] [RULE24]
               if (byteSeen_reg && bitCnt_reg == 3'h0) begin
                  wrEn = 1'b1;
                  readClr_next = 1'b1;
               end
            end else begin
               if (!sclkPrev_reg && sclkS) begin
                  sdo_next = shift_reg[WORD_BITS-1]; // [RULE22]
               end
               if (sclkPrev_reg && !sclkS) begin
                  // the shifter chains input behind output, msb first [RULE22]
                  shift_next = {shift_reg[WORD_BITS-2:0], sdiS};
                  bitCnt_next = 3'(bitCnt_reg + 3'h1);
                  if (bitCnt_reg == 3'h7) begin
                     byteSeen_next = 1'b1;
                  end
               end
            end
         end
         default: begin
            linkState_next = LINK_IDLE;
            sdoOe_next = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         linkState_reg <= LINK_IDLE;
         shift_reg <= '0;
         reported_reg <= '0;
         bitCnt_reg <= 3'h0;
         byteSeen_reg <= 1'b0;
         sdo_reg <= 1'b0;
         sdoOe_reg <= 1'b0;
         readClr_reg <= 1'b0;
         sclkPrev_reg <= 1'b0;
         csPrev_reg <= 1'b1;
      end else begin
         linkState_reg <= linkState_next;
         shift_reg <= shift_next;
         reported_reg <= reported_next;
         bitCnt_reg <= bitCnt_next;
         byteSeen_reg <= byteSeen_next;
         sdo_reg <= sdo_next;
         sdoOe_reg <= sdoOe_next;
         readClr_reg <= readClr_next;
         sclkPrev_reg <= sclkS;
         csPrev_reg <= csS;
      end
   end

   assign sdo = sdo_reg;
   assign sdoOe = sdoOe_reg;

   // ************************************************************
   // configuration registers
   // ************************************************************
   assign wAddr = shift_reg[ADDR_LSB+2:ADDR_LSB];
   assign wSel = shift_reg[SEL_BIT] ? 1 : 0;

   always_comb begin
      onSpi_next = onSpi_reg;
      lowSel_next = lowSel_reg;
      highSel_next = highSel_reg;
      blankSel_next = blankSel_reg;
      olDis_next = olDis_reg;
      uvDis_next = uvDis_reg;
      ovDis_next = ovDis_reg;
      if (!supOk) begin
         // lost logic supply falls back to defaults [RULE1] [RULE2]
         onSpi_next = {NUM_OUT{ON_SPI_RST}};
         lowSel_next = {NUM_OUT{LOW_SEL_RST}};
         highSel_next = {NUM_OUT{HIGH_SEL_RST}};
         blankSel_next = {NUM_OUT{BLANK_SEL_RST}};
         olDis_next = {NUM_OUT{OLDIS_RST}};
         uvDis_next = UVDIS_RST;
         ovDis_next = OVDIS_RST;
      end else if (wrEn && wAddr == ADDR_OUTCTL) begin
         onSpi_next[0] = shift_reg[OUTCTL_ON0_BIT];
         onSpi_next[1] = shift_reg[OUTCTL_ON1_BIT];
      end else if (wrEn && wAddr == ADDR_CURLIM) begin
         highSel_next[wSel] = shift_reg[CURLIM_HIGH_BIT]; // [RULE18]
         lowSel_next[wSel] = shift_reg[2:0];
      end else if (wrEn && wAddr == ADDR_LOADTIME) begin
         olDis_next[wSel] = shift_reg[LOADTIME_OLDIS_BIT];
         blankSel_next[wSel] = shift_reg[1:0];
      end else if (wrEn && wAddr == ADDR_SUPPLY && shift_reg[SEL_BIT]) begin
         uvDis_next = shift_reg[SUPPLY_UVDIS_BIT];
         ovDis_next = shift_reg[SUPPLY_OVDIS_BIT];
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         onSpi_reg <= {NUM_OUT{ON_SPI_RST}};
         lowSel_reg <= {NUM_OUT{LOW_SEL_RST}};
         highSel_reg <= {NUM_OUT{HIGH_SEL_RST}};
         blankSel_reg <= {NUM_OUT{BLANK_SEL_RST}};
         olDis_reg <= {NUM_OUT{OLDIS_RST}};
         uvDis_reg <= UVDIS_RST;
         ovDis_reg <= OVDIS_RST;
      end else begin
         onSpi_reg <= onSpi_next;
         lowSel_reg <= lowSel_next;
         highSel_reg <= highSel_next;
         blankSel_reg <= blankSel_next;
         olDis_reg <= olDis_next;
         uvDis_reg <= uvDis_next;
         ovDis_reg <= ovDis_next;
      end
   end

   assign lowTierCurrentLimit = lowSel_reg; // [RULE18]
   assign highTierCurrentLimit = highSel_reg;

   // ************************************************************
   // per-output protection
   // ************************************************************
   assign ovActive = supOv & ~ovDis_reg; // [RULE10]
   assign uvActive = supUv & ~uvDis_reg; // [RULE14]
   // only the bits actually shifted out are cleared, later events survive
   assign clrMask = (readClr_reg ? reported_reg : '0) | {WORD_BITS{~supOk}}; // [RULE5] [RULE1]

   for (genvar i = 0; i < NUM_OUT; i++) begin : g_out
      assign cmdOn[i] = dIn[i] | onSpi_reg[i]; // [RULE26] [RULE2]
      assign clrOt[i] = clrMask[ST_OT_LSB+i];
      assign clrOl[i] = clrMask[ST_OL_LSB+i];
      assign clrOc[i] = clrMask[ST_OC_LSB+i];
      dsf_output_guard u_guard (
         .clk(clk),
         .rst_n(rst_n),
         .cmdOn(cmdOn[i]),
         .ovActive(ovActive),
         .uvActive(uvActive),
         .supplyCritical(supCrit),
         .overTemp(ot[i]),
         .openLoad(ol[i]),
         .gateOff(gOff[i]),
         .ocLow(ocL[i]),
         .ocHigh(ocH[i]),
         .blankCycles(BLANK_CYC[blankSel_reg[i]]),
         .olDisable(olDis_reg[i]),
         .clrOt(clrOt[i]),
         .clrOl(clrOl[i]),
         .clrOc(clrOc[i]),
         .outOn(outOn[i]),
         .otFlag(otFlag[i]),
         .olFlag(olFlag[i]),
         .ocFlag(ocFlag[i]),
         .faultActive(guardFault[i])
      );
   end

   assign powerOutputOn = outOn;

   // ************************************************************
   // supply flags and fault indicator
   // ************************************************************
   always_comb begin
      ovFlag_next = ovActive | (ovFlag_reg & ~clrMask[ST_OV_BIT]); // [RULE9]
      uvFlag_next = uvActive | (uvFlag_reg & ~clrMask[ST_UV_BIT]); // [RULE11] [RULE12]
      faultN_next = ~(|guardFault | ovActive | uvActive); // [RULE3] [RULE4] [RULE11]
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ovFlag_reg <= 1'b0;
         uvFlag_reg <= 1'b0;
         faultN_reg <= 1'b1;
      end else begin
         ovFlag_reg <= ovFlag_next;
         uvFlag_reg <= uvFlag_next;
         faultN_reg <= faultN_next;
      end
   end

   assign faultIndicatorN = faultN_reg;

   always_comb begin
      statusByte = '0;
      statusByte[ST_UV_BIT] = uvFlag_reg;
      statusByte[ST_OV_BIT] = ovFlag_reg; // [RULE9]
      statusByte[ST_OT_LSB+1:ST_OT_LSB] = otFlag;
      statusByte[ST_OL_LSB+1:ST_OL_LSB] = olFlag;
      statusByte[ST_OC_LSB+1:ST_OC_LSB] = ocFlag;
   end
endmodule

`default_nettype wire

//--- bench/dsf_spi_host.sv
// Purpose: host side of the serial link, one message per call
// Assumes: clk only paces the link
// Notes: serial clock 8 core clocks high, 8 low (64 ns)
`timescale 1ns/100ps
`default_nettype none
module dsf_spi_host (
   // pacing clock
   input wire logic clk,
   // serial link
   output logic sclk,
   output logic sdi,
   output logic csN,
   input wire logic sdo,
   input wire logic sdoOe
);
   wire logic soLine;
   // **********
   // message engine
   // **********
   // released data out floats and never matches
   assign soLine = sdoOe ? sdo : 1'bz;
   initial begin
      sclk = 1'b0;
      sdi = 1'b0;
      csN = 1'b1;
   end
   // nbits under 8 sends a short message
   task automatic xfer(input logic [7:0] tx, input int nbits, output logic [7:0] rx);
      rx = '0;
      csN = 1'b0;
      repeat (8) @(negedge clk);
      for (int i = 0; i < nbits; i++) begin
         sclk = 1'b1;
         sdi = tx[7-i];
         repeat (8) @(negedge clk);
         rx = {rx[6:0], soLine};
         sclk = 1'b0;
         repeat (8) @(negedge clk);
      end
      // sclk is parked low before select rises
      sdi = 1'b0;
      csN = 1'b1;
      repeat (12) @(negedge clk);
   endtask
endmodule
`default_nettype wire

//--- bench/dsf_supervisor_properties.sv
// Purpose: port checks on the fault supervisor
// Assumes: overcurrent hits output zero, overheat output one
// Notes: disable bits are not ports here
`timescale 1ns/100ps
`default_nettype none
module dsf_supervisor_properties import dsf_pkg::*; (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // watched inputs
   input wire logic logicSupplyOk,
   input wire logic supplyBelowCritical,
   input wire logic [NUM_OUT-1:0] directOutputInputs,
   input wire logic [NUM_OUT-1:0] overTemp,
   input wire logic [NUM_OUT-1:0] overCurrentHigh,
   input wire logic csN,
   // watched outputs
   input wire logic sdoOe,
   input wire logic [NUM_OUT-1:0] powerOutputOn,
   input wire logic [NUM_OUT-1:0][2:0] lowTierCurrentLimit,
   input wire logic [NUM_OUT-1:0] highTierCurrentLimit,
   input wire logic faultIndicatorN
);
   // **********
   // checks
   // **********
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence s_ocHit; $rose(overCurrentHigh[0]) && powerOutputOn[0]; endsequence
   sequence s_ocTrip; ##[1:5] !powerOutputOn[0] ##[0:3] !faultIndicatorN; endsequence
   property p_oc_trip; s_ocHit |-> s_ocTrip; endproperty
   a_oc_trip: assert property (p_oc_trip) else $error("overcurrent not tripped");
   property p_oc_hold; $fell(powerOutputOn[0]) && overCurrentHigh[0] ##1 directOutputInputs[0] [*8]
      |-> !powerOutputOn[0]; endproperty
   a_oc_hold: assert property (p_oc_hold) else $error("latched output came back");
   property p_sdo_idle; csN [*6] |-> !sdoOe; endproperty
   a_sdo_idle: assert property (p_sdo_idle) else $error("data out driven while idle");
   property p_sdo_drive; (!csN && logicSupplyOk) [*6] |-> sdoOe; endproperty
   a_sdo_drive: assert property (p_sdo_drive) else $error("data out not driven");
   property p_critical; supplyBelowCritical [*6] |-> powerOutputOn == '0; endproperty
   a_critical: assert property (p_critical) else $error("output on below critical supply");
   property p_ot_off; overTemp[1] [*6] |-> !powerOutputOn[1]; endproperty
   a_ot_off: assert property (p_ot_off) else $error("output on while hot");
   property p_ot_fault; (overTemp[1] && directOutputInputs[1]) [*7] |-> !faultIndicatorN; endproperty
   a_ot_fault: assert property (p_ot_fault) else $error("hot output not flagged");
   property p_supply_loss; !logicSupplyOk [*6] |-> lowTierCurrentLimit == '0 && highTierCurrentLimit == '0;
   endproperty
   a_supply_loss: assert property (p_supply_loss) else $error("limits kept without supply");
endmodule
bind dsf_supervisor dsf_supervisor_properties u_props (.clk(clk), .rst_n(rst_n),
   .logicSupplyOk(logicSupplyOk), .supplyBelowCritical(supplyBelowCritical),
   .directOutputInputs(directOutputInputs), .overTemp(overTemp), .overCurrentHigh(overCurrentHigh),
   .csN(csN), .sdoOe(sdoOe), .powerOutputOn(powerOutputOn), .lowTierCurrentLimit(lowTierCurrentLimit),
   .highTierCurrentLimit(highTierCurrentLimit), .faultIndicatorN(faultIndicatorN));
`default_nettype wire

//--- bench/dsf_supervisor_bench.sv
// Purpose: self-checking bench for the fault supervisor
// Assumes: inputs change on the falling edge
// Notes: every 8-bit transfer checks its status byte; the short 7-bit transfer does not
`timescale 1ns/100ps
`default_nettype none
module dsf_supervisor_bench import dsf_pkg::*;;
   logic clk = 1'b0, rst_n = 1'b0, logicSupplyOk = 1'b1;
   logic supplyOverVoltage = 1'b0, supplyUnderVoltage = 1'b0, supplyBelowCritical = 1'b0;
   logic [NUM_OUT-1:0] directOutputInputs = '0, overTemp = '0, openLoad = '0, overCurrentLow = '0;
   logic [NUM_OUT-1:0] overCurrentHigh = '0, gateOff, powerOutputOn, highTierCurrentLimit;
   logic [NUM_OUT-1:0][2:0] lowTierCurrentLimit;
   logic sclk, sdi, csN, sdo, sdoOe, faultIndicatorN;
   logic [7:0] rx;
   int failCount = 0, nCompared = 0;
   always #2 clk = ~clk;
   // gate reads pulled low while the output is off
   assign gateOff = ~powerOutputOn;
   dsf_spi_host host (.clk(clk), .sclk(sclk), .sdi(sdi), .csN(csN), .sdo(sdo), .sdoOe(sdoOe));
   dsf_supervisor dut (.clk(clk), .rst_n(rst_n), .logicSupplyOk(logicSupplyOk),
      .supplyOverVoltage(supplyOverVoltage), .supplyUnderVoltage(supplyUnderVoltage),
      .supplyBelowCritical(supplyBelowCritical), .directOutputInputs(directOutputInputs),
      .overTemp(overTemp), .openLoad(openLoad), .gateOff(gateOff), .overCurrentLow(overCurrentLow),
      .overCurrentHigh(overCurrentHigh), .sclk(sclk), .sdi(sdi), .csN(csN), .sdo(sdo), .sdoOe(sdoOe),
      .powerOutputOn(powerOutputOn), .lowTierCurrentLimit(lowTierCurrentLimit),
      .highTierCurrentLimit(highTierCurrentLimit), .faultIndicatorN(faultIndicatorN));
   // **********
   // helpers
   // **********
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      nCompared++;
      if (seen !== exp) begin
         failCount++;
         $display("MISMATCH %0t: got %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic st(input logic [1:0] pwr, input logic flt);
      repeat (12) @(negedge clk);
      chk(8'({faultIndicatorN, powerOutputOn}), 8'({flt, pwr}));
   endtask
   task automatic rd(input logic [7:0] cmd, input logic [7:0] exp);
      host.xfer(cmd, 8, rx);
      chk(rx, exp);
   endtask
   // off then on: the only way out of a latch-off
   task automatic recmd();
      directOutputInputs[0] = 1'b0;
      repeat (8) @(negedge clk);
      directOutputInputs[0] = 1'b1;
   endtask
   task automatic results();
      if (failCount == 0 && nCompared > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      repeat (60000) @(posedge clk);
      failCount++;
      results();
   end
   // **********
   // scenarios
   // **********
   initial begin
      repeat (12) @(negedge clk);
      rst_n = 1'b1;
      st(2'b00, 1'b1);
      rd(8'h00, 8'h00);
      directOutputInputs = 2'b11;
      supplyOverVoltage = 1'b1;
      st(2'b00, 1'b0);
      supplyOverVoltage = 1'b0;
      st(2'b11, 1'b1);
      rd(8'h00, 8'h02);
      rd(8'he1, 8'h00);
      supplyOverVoltage = 1'b1;
      st(2'b11, 1'b1);
      supplyOverVoltage = 1'b0;
      overTemp = 2'b10;
      st(2'b01, 1'b0);
      overTemp = 2'b00;
      st(2'b11, 1'b1);
      rd(8'h00, 8'h08);
      overCurrentHigh = 2'b01;
      st(2'b10, 1'b0);
      overCurrentHigh = 2'b00;
      st(2'b10, 1'b0);
      recmd();
      st(2'b11, 1'b1);
      rd(8'h00, 8'h40);
      overCurrentLow = 2'b01;
      repeat (40) @(negedge clk);
      overCurrentLow = 2'b00;
      st(2'b11, 1'b1);
      overCurrentLow = 2'b01;
      repeat (80) @(negedge clk);
      overCurrentLow = 2'b00;
      st(2'b10, 1'b0);
      recmd();
      rd(8'h00, 8'h40);
      for (int i = 0; i < 16; i++) begin
         rd(8'h20 + 8'(i), 8'h00);
         chk(8'({highTierCurrentLimit[0], lowTierCurrentLimit[0]}), 8'(i));
      end
      host.xfer(8'h20, 7, rx);
      chk(8'(lowTierCurrentLimit[0]), 8'h07);
      logicSupplyOk = 1'b0;
      st(2'b11, 1'b1);
      logicSupplyOk = 1'b1;
      directOutputInputs = 2'b00;
      rd(8'h11, 8'h00);
      st(2'b01, 1'b1);
      rd(8'h10, 8'h00);
      openLoad = 2'b01;
      st(2'b00, 1'b0);
      rd(8'h00, 8'h10);
      openLoad = 2'b00;
      rd(8'h00, 8'h10);
      rd(8'h38, 8'h00);
      openLoad = 2'b01;
      overTemp = 2'b11;
      st(2'b00, 1'b1);
      overTemp = 2'b00;
      supplyUnderVoltage = 1'b1;
      st(2'b00, 1'b0);
      supplyUnderVoltage = 1'b0;
      st(2'b00, 1'b1);
      rd(8'h00, 8'h01);
      directOutputInputs = 2'b01;
      supplyUnderVoltage = 1'b1;
      st(2'b00, 1'b0);
      supplyUnderVoltage = 1'b0;
      st(2'b00, 1'b0);
      recmd();
      st(2'b01, 1'b1);
      rd(8'he2, 8'h01);
      supplyUnderVoltage = 1'b1;
      st(2'b01, 1'b1);
      supplyBelowCritical = 1'b1;
      st(2'b00, 1'b1);
      supplyBelowCritical = 1'b0;
      supplyUnderVoltage = 1'b0;
      rd(8'h00, 8'h00);
      results();
   end
endmodule
`default_nettype wire
